/* verilog/updown_timer_pkg.sv */
// Shared constants and carrier types for the up/down reload timer.
package updown_timer_pkg;

  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned OSC_PER_STATE   = 3;
  localparam logic [15:0] COUNT_ALL_ONES  = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] RELOAD_RESET    = 16'h0000;
  localparam logic [1:0]  PRESCALE_RESET  = 2'h0;
  localparam logic [1:0]  SERIAL_NONE     = 2'h0;

  // Software control bits, held by the core's register file outside this block.
  typedef struct packed {
    logic       run_control;
    logic       counter_timer_select;
    logic       external_enable;
    logic       down_count_enable;
    logic       clock_output_enable;
    logic [1:0] prescale_field;
    logic [1:0] serial_select_bits;
  } ctrl_t;

  // Byte writes from the core.
  typedef struct packed {
    logic       count_low_we;
    logic       count_high_we;
    logic       reload_low_we;
    logic       reload_high_we;
    logic [7:0] wdata;
  } wr_t;

endpackage : updown_timer_pkg

/* verilog/pin_sync.sv */
// Three-stage pin synchroniser with agreement of the last two stages.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Pin and result
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // The level moves only once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      level_o <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* verilog/updown_timer.sv */
// Sixteen-bit reload timer: up/down, clock-out and baud generator modes.
`timescale 1ns/10ps
`default_nettype none
module updown_timer (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  // Control and writes from the core
  input  wire updown_timer_pkg::ctrl_t  ctrl_i,
  input  wire updown_timer_pkg::wr_t    wr_i,
  input  wire logic                     down_count_enable_set_i,
  input  wire logic                     overflow_flag_clr_i,
  input  wire logic                     external_flag_clr_i,
  // Pins
  input  wire logic                     direction_capture_pin_i,
  input  wire logic                     count_pin_i,
  output logic                          timer_output_pin_o,
  output logic                          timer_output_pin_oe_n_o,
  // Status
  output logic [15:0]                   count_o,
  output logic [15:0]                   reload_o,
  output logic                          down_count_enable_o,
  output logic                          overflow_flag_o,
  output logic                          external_flag_o,
  output logic                          irq_o,
  // Baud ticks to serial ports 0..2
  output logic [2:0]                    baud_tick_o
);
  localparam int unsigned PRE_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  logic dir_lvl;
  logic cnt_lvl;
  logic cnt_prev_q;
  logic dir_prev_q;
  logic [1:0] state_div_q;
  logic [PRE_W-1:0] pre_q;
  logic tick;
  logic state_end;
  logic baud_mode;
  logic clkout_mode;
  logic updown_mode;
  logic ext_fall;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic wrap_up;
  logic wrap_down;
  logic wrap;
  logic toggle_q;
  logic down_count_enable_q;

  pin_sync u_dir_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .pin_i   (direction_capture_pin_i),
    .level_o (dir_lvl)
  );

  pin_sync u_cnt_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .pin_i   (count_pin_i),
    .level_o (cnt_lvl)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_prev_q <= 1'b1;
      dir_prev_q <= 1'b1;
    end else begin
      cnt_prev_q <= cnt_lvl;
      dir_prev_q <= dir_lvl;
    end
  end

  assign ext_fall = dir_prev_q & ~dir_lvl;

  // any nonzero serial select is baud mode
  assign baud_mode   = ctrl_i.serial_select_bits != updown_timer_pkg::SERIAL_NONE;
  assign clkout_mode = ctrl_i.clock_output_enable & ~baud_mode;
  assign updown_mode = down_count_enable_q & ~baud_mode & ~clkout_mode;

  ////////////////////////////////////////////////////////////////////////////
  // state time of three clocks, then prescaler of pre+1 states
  assign state_end = state_div_q == 2'(updown_timer_pkg::OSC_PER_STATE - 1);

  always_ff @(posedge clk_i) begin
    if (srst_i || !ctrl_i.run_control) begin
      state_div_q <= 2'h0;
    end else if (state_end) begin
      state_div_q <= 2'h0;
    end else begin
      state_div_q <= state_div_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || !ctrl_i.run_control) begin
      pre_q <= '0;
    end else if (state_end) begin
      pre_q <= (pre_q >= PRE_W'(ctrl_i.prescale_field)) ? '0 : pre_q + PRE_W'(1);
    end
  end

  // timer mode counts once every one to four state times, counter mode once per count pin fall
  assign tick = ctrl_i.run_control &
                (ctrl_i.counter_timer_select ? (cnt_prev_q & ~cnt_lvl)
                 : (state_end && pre_q == PRE_W'(ctrl_i.prescale_field)));

  ////////////////////////////////////////////////////////////////////////////
  assign wrap_up   = tick & (~updown_mode | dir_lvl) & (count_q == updown_timer_pkg::COUNT_ALL_ONES);
  // underflow when count matches the reload pair
  assign wrap_down = tick & updown_mode & ~dir_lvl & (count_q == reload_q);
  assign wrap      = wrap_up | wrap_down;

  // byte writes take priority over hardware reloads
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_q <= updown_timer_pkg::COUNT_RESET;
    end else begin
      if (wrap_down) begin
        count_q <= updown_timer_pkg::COUNT_ALL_ONES;
      end else if (wrap_up) begin
        // every up wrap reloads from the shared pair
        count_q <= reload_q;
      end else if (tick) begin
        count_q <= (updown_mode && !dir_lvl) ? count_q - 16'h1 : count_q + 16'h1;
      end else if (ext_fall && ctrl_i.external_enable && !baud_mode && !updown_mode) begin
        // pin-driven reload needs the external enable and happens only outside baud and up/down modes
        count_q <= reload_q;
      end
      if (wr_i.count_low_we) begin
        count_q[7:0] <= wr_i.wdata;
      end
      if (wr_i.count_high_we) begin
        count_q[15:8] <= wr_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reload_q <= updown_timer_pkg::RELOAD_RESET;
    end else begin
      if (wr_i.reload_low_we) begin
        reload_q[7:0] <= wr_i.wdata;
      end
      if (wr_i.reload_high_we) begin
        reload_q[15:8] <= wr_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      down_count_enable_q <= 1'b0;
    end else begin
      down_count_enable_q <= down_count_enable_set_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud and clock-out wraps never set the overflow flag; set beats clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      overflow_flag_o <= 1'b0;
    end else if (wrap && !baud_mode && !clkout_mode) begin
      overflow_flag_o <= 1'b1;
    end else if (overflow_flag_clr_i) begin
      overflow_flag_o <= 1'b0;
    end
  end

  // toggles as a seventeenth bit in up/down mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      external_flag_o <= 1'b0;
    end else if (updown_mode && wrap) begin
      external_flag_o <= ~external_flag_o;
    end else if (!updown_mode && ext_fall && (ctrl_i.external_enable || baud_mode)) begin
      external_flag_o <= 1'b1;
    end else if (external_flag_clr_i) begin
      external_flag_o <= 1'b0;
    end
  end

  // external flag interrupts only when enabled and not up/down
  assign irq_o = overflow_flag_o |
                 (external_flag_o & ctrl_i.external_enable & ~updown_mode);

  ////////////////////////////////////////////////////////////////////////////
  // wraps feed a divide-by-two stage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      toggle_q <= 1'b0;
    end else if (wrap && ctrl_i.clock_output_enable) begin
      toggle_q <= ~toggle_q;
    end
  end

  // timer input selection gates the divided clock to the pin
  assign timer_output_pin_o      = toggle_q;
  assign timer_output_pin_oe_n_o = ~(ctrl_i.clock_output_enable & ~ctrl_i.counter_timer_select);

  // serial select routes the wrap to one port
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      baud_tick_o <= 3'h0;
    end else begin
      baud_tick_o <= 3'h0;
      if (baud_mode && wrap_up) begin
        baud_tick_o[ctrl_i.serial_select_bits - 2'h1] <= 1'b1;
      end
    end
  end

  assign count_o             = count_q;
  assign reload_o            = reload_q;
  assign down_count_enable_o = down_count_enable_q;

  ////////////////////////////////////////////////////////////////////////////
  // up wrap reloads
  a_up_wrap_reload: assert property (@(posedge clk_i) disable iff (srst_i)
    wrap_up && !wr_i.count_low_we && !wr_i.count_high_we |=> count_q == $past(reload_q))
    else $error("up wrap did not reload");
  a_down_wrap_ones: assert property (@(posedge clk_i) disable iff (srst_i)
    wrap_down && !wr_i.count_low_we && !wr_i.count_high_we |=> count_q == 16'hFFFF)
    else $error("down wrap did not load ones");
  a_ext_toggle: assert property (@(posedge clk_i) disable iff (srst_i)
    updown_mode && wrap |=> external_flag_o != $past(external_flag_o))
    else $error("external flag did not toggle");
  a_baud_no_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    baud_mode && !overflow_flag_o |=> !overflow_flag_o)
    else $error("overflow flag set in baud mode");
  a_flag_irq: assert property (@(posedge clk_i) disable iff (srst_i)
    overflow_flag_o |-> irq_o)
    else $error("overflow without interrupt");
  a_clkout_toggle: assert property (@(posedge clk_i) disable iff (srst_i)
    wrap && ctrl_i.clock_output_enable |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("output did not toggle");
  a_baud_no_reload: assert property (@(posedge clk_i) disable iff (srst_i)
    baud_mode && !tick && !wr_i.count_low_we && !wr_i.count_high_we
    |=> count_q == $past(count_q))
    else $error("count moved without tick in baud mode");
  a_write_wins: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_i.count_low_we |=> count_q[7:0] == $past(wr_i.wdata))
    else $error("write lost to reload");
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
    tick && !ctrl_i.counter_timer_select && ctrl_i.run_control |=> !tick [*2])
    else $error("ticks closer than one state time");
  a_reset_down_count_enable: assert property (@(posedge clk_i) srst_i |=> !down_count_enable_q)
    else $error("down count enable not cleared");

  c_up_wrap: cover property (@(posedge clk_i) disable iff (srst_i) wrap_up && updown_mode);
  c_down_wrap: cover property (@(posedge clk_i) disable iff (srst_i) wrap_down);
  c_baud_tick: cover property (@(posedge clk_i) disable iff (srst_i) |baud_tick_o);
  c_clkout: cover property (@(posedge clk_i) disable iff (srst_i) clkout_mode && wrap);
endmodule : updown_timer
`default_nettype wire

/* bench/serial_port_model.sv */
// Serial port side: counts baud ticks per port and flags overlapping ticks.
`timescale 1ns/10ps
`default_nettype none
module serial_port_model (
  // Clock and clear
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  // Ticks from the timer
  input  wire logic [2:0] baud_tick_i,
  // Tallies
  output int              tick_cnt_o [3],
  output int              overlap_o
);
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      tick_cnt_o <= '{0, 0, 0};
      overlap_o  <= 0;
    end else begin
      for (int i = 0; i < 3; i++) tick_cnt_o[i] <= tick_cnt_o[i] + int'(baud_tick_i[i]);
      if ($countones(baud_tick_i) > 1) overlap_o <= overlap_o + 1;
    end
  end
endmodule : serial_port_model
`default_nettype wire

/* bench/updown_timer_test.sv */
// Self-checking bench for the up/down reload timer.
`timescale 1ns/10ps
`default_nettype none
module updown_timer_test;
  logic clk_i = 1'b0, srst_i = 1'b1, dce = 1'b0, oclr = 1'b0, eclr = 1'b0;
  logic dir = 1'b1, cpin = 1'b1, pin, oe_n, dce_o, ovf, ext, irq, pclr = 1'b1;
  logic [15:0] cnt, rld, rl;
  logic [2:0] bt;
  updown_timer_pkg::ctrl_t ctrl = '0;
  updown_timer_pkg::wr_t wr = '0;
  int failures = 0, total_checks = 0, n, ticks [3], ovl, tg;
  updown_timer i_dut (.clk_i(clk_i), .srst_i(srst_i), .ctrl_i(ctrl), .wr_i(wr),
    .down_count_enable_set_i(dce), .overflow_flag_clr_i(oclr), .external_flag_clr_i(eclr),
    .direction_capture_pin_i(dir), .count_pin_i(cpin), .timer_output_pin_o(pin),
    .timer_output_pin_oe_n_o(oe_n), .count_o(cnt), .reload_o(rld),
    .down_count_enable_o(dce_o), .overflow_flag_o(ovf), .external_flag_o(ext),
    .irq_o(irq), .baud_tick_o(bt));
  serial_port_model i_sp (.clk_i(clk_i), .clr_i(pclr), .baud_tick_i(bt),
    .tick_cnt_o(ticks), .overlap_o(ovl));
  initial forever #20 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // Integer model of the count: any move that no byte write caused must be the
  // successor that the mode's rules give, so every tick is checked, not just the ends.
  int unsigned m_last = 0, m_rld = 0, m_exp;
  bit m_free = 1'b0, m_down = 1'b0;
  always @(posedge clk_i) begin
    if (m_free && cnt !== 16'(m_last)) begin
      m_exp = m_down ? ((m_last == m_rld) ? 32'hFFFF : m_last - 1)
                     : ((m_last == 32'hFFFF) ? m_rld : m_last + 1);
      chk(cnt === 16'(m_exp), "model count step");
    end
    m_free = !srst_i && wr == '0;
    m_last = cnt;
    m_rld  = rld;
    m_down = dce_o === 1'b1 && ctrl.serial_select_bits == 2'h0
             && !ctrl.clock_output_enable && dir === 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : step
  task automatic wr16(input bit rel, input logic [15:0] v);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i);
      wr <= '{b == 0 && !rel, b == 1 && !rel, b == 0 && rel, b == 1 && rel, v[8*b+:8]};
      @(posedge clk_i);
      wr <= '0;
      #1;
      chk((rel ? rld[8*b+:8] : cnt[8*b+:8]) === v[8*b+:8], "byte write");
    end
  endtask : wr16
  task automatic run(input bit r);
    @(posedge clk_i);
    ctrl.run_control <= r;
    step(1);
  endtask : run
  task automatic wait_ovf();
    for (int i = 0; i < 60 && ovf !== 1'b1; i++) step(1);
  endtask : wait_ovf
  task automatic gap(input bit sel, output int k);
    logic c;
    c = sel ? pin : cnt[0];
    k = 0;
    while ((sel ? pin : cnt[0]) === c && k < 200) begin
      step(1);
      k++;
    end
  endtask : gap
  task automatic pulse_clr();
    @(posedge clk_i);
    oclr <= 1'b1;
    eclr <= 1'b1;
    @(posedge clk_i);
    oclr <= 1'b0;
    eclr <= 1'b0;
    step(2);
  endtask : pulse_clr
  task automatic complete_run();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(95356));
    step(3);
    srst_i <= 1'b0;
    step(1);
    chk(dce_o === 1'b0 && ovf === 1'b0 && cnt === 16'h0000, "reset state");
    @(posedge clk_i);
    dce <= 1'b1;
    ctrl.external_enable <= 1'b1;
    step(10);
    chk(dce_o === 1'b1, "down count enable");
    rl = 16'($urandom % 32'hFFF0);
    wr16(1'b1, rl);
    wr16(1'b0, 16'hFFFD);
    run(1'b1);
    wait_ovf();
    chk(cnt === rl && irq === 1'b1 && ext === 1'b1, "up wrap reload");
    run(1'b0);
    @(posedge clk_i);
    oclr <= 1'b1;
    @(posedge clk_i);
    oclr <= 1'b0;
    step(2);
    chk(irq === 1'b0 && ext === 1'b1, "external flag no irq");
    dir <= 1'b0;
    wr16(1'b0, rl + 16'h0003);
    step(8);
    run(1'b1);
    wait_ovf();
    chk(cnt === 16'hFFFF && ext === 1'b0, "down reload ones");
    run(1'b0);
    dce <= 1'b0;
    pulse_clr();
    wr16(1'b1, 16'h0000);
    for (int p = 0; p < 4; p++) begin
      ctrl.prescale_field <= 2'(p);
      wr16(1'b0, 16'h0000);
      run(1'b1);
      gap(1'b0, n);
      gap(1'b0, n);
      chk(n == 3 * (p + 1), "tick period");
      run(1'b0);
    end
    ctrl <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 2'h0};
    wr16(1'b0, 16'h0000);
    run(1'b1);
    for (int i = 0; i < 5; i++) begin
      cpin <= 1'b0;
      step(8);
      cpin <= 1'b1;
      step(8);
    end
    chk(cnt === 16'h0005 && oe_n === 1'b1, "counter mode");
    run(1'b0);
    ctrl.counter_timer_select <= 1'b0;
    wr16(1'b1, 16'hFFF0);
    wr16(1'b0, 16'hFFF0);
    run(1'b1);
    chk(oe_n === 1'b0, "clock out drives pin");
    gap(1'b1, n);
    gap(1'b1, n);
    chk(n == 48 && ovf === 1'b0 && irq === 1'b0, "clock out half period");
    // baud runs are set up only while stopped.
    run(1'b0);
    wr16(1'b1, 16'hFFFE);
    for (int s = 1; s < 4; s++) begin
      run(1'b0);
      ctrl.serial_select_bits <= 2'(s);
      wr16(1'b0, 16'hFFFE);
      pclr <= 1'b0;
      tg = 0;
      run(1'b1);
      for (int i = 0; i < 120; i++) begin
        n = pin;
        step(1);
        tg += (pin !== n);
      end
      chk(ticks[s-1] >= 19 && ticks[s-1] <= 21 && ticks[s-1] - 1 <= tg && tg <= ticks[s-1] + 1
          && ticks[0] + ticks[1] + ticks[2] == ticks[s-1] && ovl == 0, "baud ticks");
      chk(ovf === 1'b0 && cnt >= 16'hFFFE, "baud rollover");
      pclr <= 1'b1;
    end
    run(1'b0);
    for (int e = 1; e >= 0; e--) begin
      ctrl.external_enable <= 1'(e);
      dir <= 1'b1;
      pulse_clr();
      wr16(1'b0, 16'h5555);
      step(8);
      dir <= 1'b0;
      step(10);
      chk(ext === 1'b1 && irq === 1'(e) && cnt === 16'h5555, "baud pin edge");
    end
    complete_run();
  end
endmodule : updown_timer_test
`default_nettype wire
